//--- design/ufd_dma_desc.sv
`timescale 1ns/10ps
module ufd_dma_desc #(
    parameter int DESC_DEPTH = 256
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // descriptor serving port toward the USB engine
    input wire logic srv_rd,
    input wire logic [7:0] srv_idx,
    output logic [7:0] srv_data,
    // endpoint DMA services and DMA channels
    input wire logic [ufd_pkg::UFD_NUM_EP-1:0] ep_dma_req,
    output logic [ufd_pkg::UFD_NUM_EP-1:0] ep_dma_ack,
    output logic [ufd_pkg::UFD_NUM_CH-1:0] ch_dma_req,
    input wire logic [ufd_pkg::UFD_NUM_CH-1:0] ch_dma_ack,
    output ufd_pkg::ufd_route_s [ufd_pkg::UFD_NUM_CH-1:0] ch_route,
    // parsed descriptor view
    output ufd_pkg::ufd_cfg_info_s cfg_info,
    output ufd_pkg::ufd_ep_info_s [ufd_pkg::UFD_NUM_EP-1:0] ep_info,
    output logic [7:0] iface_count
);
    import ufd_pkg::*;

    // ==============================
    // storage and registers
    logic [7:0] desc_mem [DESC_DEPTH];
    logic [15:0] chan_map;
    logic [31:0] desc_off;
    logic desc_hit;
    logic [7:0] desc_idx;
    logic scan_start;
    logic scan_busy;
    logic scan_done;
    logic order_err;
    logic len_err;
    logic seen_if;
    logic [8:0] ptr;
    logic [16:0] limit;
    logic [7:0] cur_len;
    logic [7:0] cur_type;
    logic [16:0] next_ptr;
    logic [7:0] ep_num;
    logic [7:0] ep_addr_byte;
    logic [7:0] ep_attr_byte;

    function automatic logic [7:0] byte_at(input logic [8:0] base, input logic [7:0] ofs);
        logic [8:0] idx;
        idx = base + {1'b0, ofs};
        return desc_mem[idx[7:0]];
    endfunction

    assign desc_off = reg_addr - UFD_DESC_BASE;
    assign desc_hit = desc_off < 32'(DESC_DEPTH);
    assign desc_idx = desc_off[7:0];
    assign scan_start = reg_wr && reg_addr == UFD_SCAN_CTRL_ADDR && reg_wdata[UFD_SCAN_START_BIT];

    // a process, so that storage writes re-evaluate the walker view, not only pointer moves
    always_comb begin
        cur_len = byte_at(ptr, UFD_OFS_LEN);
        cur_type = byte_at(ptr, UFD_OFS_TYPE);
        ep_addr_byte = byte_at(ptr, UFD_EP_ADDR);
        ep_attr_byte = byte_at(ptr, UFD_EP_ATTR);
        next_ptr = {8'h00, ptr} + {9'h000, cur_len};
        ep_num = ep_addr_byte & 8'h0F;
    end

    // ==============================
    // channel map register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_map <= UFD_MAP_RESET;
        end else if (ce && reg_wr && reg_addr == UFD_MAP_ADDR) begin
            chan_map <= reg_wdata & UFD_MAP_WMASK;
        end
    end

    // ==============================
    // descriptor storage, byte wide in the low lane
    always_ff @(posedge clk) begin
        if (ce && reg_wr && desc_hit) begin
            desc_mem[desc_idx] <= reg_wdata[7:0];
        end
    end

    // ==============================
    // register read, data one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                if (reg_addr == UFD_MAP_ADDR) begin
                    reg_rdata <= chan_map & UFD_MAP_WMASK;
                end else if (reg_addr == UFD_SCAN_STAT_ADDR) begin
                    reg_rdata[UFD_STAT_BUSY_BIT] <= scan_busy;
                    reg_rdata[UFD_STAT_DONE_BIT] <= scan_done;
                    reg_rdata[UFD_STAT_ORDER_BIT] <= order_err;
                    reg_rdata[UFD_STAT_LEN_BIT] <= len_err;
                    reg_rdata[UFD_STAT_IFCNT_LSB +: 8] <= iface_count;
                end else if (reg_addr == UFD_TOTAL_LEN_ADDR) begin
                    reg_rdata <= cfg_info.total_len;
                end else if (desc_hit) begin
                    reg_rdata <= {8'h00, desc_mem[desc_idx]};
                end
            end
        end
    end

    // ==============================
    // serving port: one byte a cycle, read from storage at srv_idx
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srv_data <= 8'h00;
        end else if (ce && srv_rd) begin
            srv_data <= desc_mem[srv_idx];
        end
    end

    // ==============================
    // descriptor walker: one descriptor per cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_busy <= 1'b0;
            scan_done <= 1'b0;
            order_err <= 1'b0;
            len_err <= 1'b0;
            seen_if <= 1'b0;
            ptr <= 9'h000;
            limit <= 17'h00000;
            iface_count <= 8'h00;
            cfg_info <= '0;
            ep_info <= '0;
        end else if (ce) begin
            if (scan_start) begin
                scan_busy <= 1'b1;
                scan_done <= 1'b0;
                order_err <= 1'b0;
                len_err <= 1'b0;
                seen_if <= 1'b0;
                ptr <= 9'h000;
                limit <= 17'(DESC_DEPTH);
                iface_count <= 8'h00;
                cfg_info <= '0;
                ep_info <= '0;
            end else if (scan_busy) begin
                if ({8'h00, ptr} >= limit) begin
                    scan_busy <= 1'b0;
                    scan_done <= 1'b1;
                end else if (cur_len == 8'h00 || next_ptr > limit) begin
                    scan_busy <= 1'b0;
                    len_err <= 1'b1;
                end else if (ptr == 9'h000) begin
                    // the configuration must lead the storage
                    if (cur_type != UFD_CFG_TYPE || cur_len != UFD_CFG_LEN) begin
                        scan_busy <= 1'b0;
                        order_err <= 1'b1;
                    end else begin
                        cfg_info.valid <= 1'b1;
                        cfg_info.total_len <= {byte_at(ptr, UFD_CFG_TOTAL_HI), byte_at(ptr, UFD_CFG_TOTAL_LO)};
                        cfg_info.num_if <= byte_at(ptr, UFD_CFG_NUM_IF);
                        cfg_info.cfg_value <= byte_at(ptr, UFD_CFG_VALUE);
                        cfg_info.string_idx <= byte_at(ptr, UFD_CFG_STRING);
                        cfg_info.attr <= byte_at(ptr, UFD_CFG_ATTR);
                        cfg_info.max_power <= byte_at(ptr, UFD_CFG_POWER);
                        if ({byte_at(ptr, UFD_CFG_TOTAL_HI), byte_at(ptr, UFD_CFG_TOTAL_LO)} < 16'(DESC_DEPTH)) begin
                            limit <= {1'b0, byte_at(ptr, UFD_CFG_TOTAL_HI), byte_at(ptr, UFD_CFG_TOTAL_LO)};
                        end
                        ptr <= next_ptr[8:0];
                    end
                end else begin
                    ptr <= next_ptr[8:0];
                    if (cur_type == UFD_CFG_TYPE) begin
                        scan_busy <= 1'b0;
                        order_err <= 1'b1;
                    end else if (cur_type == UFD_IF_TYPE) begin
                        if (cur_len != UFD_IF_LEN) begin
                            scan_busy <= 1'b0;
                            len_err <= 1'b1;
                        end else begin
                            seen_if <= 1'b1;
                            iface_count <= iface_count + 8'h01;
                        end
                    end else if (cur_type == UFD_EP_TYPE) begin
                        if (!seen_if) begin
                            scan_busy <= 1'b0;
                            order_err <= 1'b1;
                        end else if (cur_len != UFD_EP_LEN) begin
                            scan_busy <= 1'b0;
                            len_err <= 1'b1;
                        end else if (ep_num >= 8'h01 && ep_num <= 8'(UFD_NUM_EP)) begin
                            ep_info[ep_num[1:0] - 2'b01].valid <= 1'b1;
                            ep_info[ep_num[1:0] - 2'b01].dir_in <= ep_addr_byte[7];
                            ep_info[ep_num[1:0] - 2'b01].xfer <= ep_attr_byte[1:0];
                            ep_info[ep_num[1:0] - 2'b01].max_packet <=
                                {byte_at(ptr, UFD_EP_MPS_HI), byte_at(ptr, UFD_EP_MPS_LO)};
                            ep_info[ep_num[1:0] - 2'b01].interval <= byte_at(ptr, UFD_EP_INTERVAL);
                        end
                    end
                end
            end
        end
    end

    // ==============================
    // DMA routing per channel
    logic [UFD_NUM_EP-1:0] ack_hot [UFD_NUM_CH];
    logic [UFD_NUM_EP-1:0] next_ep_ack;

    for (genvar ch = 0; ch < UFD_NUM_CH; ch++) begin : g_chan
        logic [UFD_SEL_W-1:0] sel;
        assign sel = chan_map[ch*UFD_SEL_STRIDE +: UFD_SEL_W];
        always_comb begin
            ack_hot[ch] = '0;
            if (sel[UFD_SEL_EN_BIT]) begin
                ack_hot[ch][sel[1:0]] = ch_dma_ack[ch];
            end
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                ch_route[ch] <= '0;
                ch_dma_req[ch] <= 1'b0;
            end else if (ce) begin
                ch_route[ch].assigned <= sel[UFD_SEL_EN_BIT];
                ch_route[ch].endpoint <= sel[1:0];
                ch_dma_req[ch] <= sel[UFD_SEL_EN_BIT] & ep_dma_req[sel[1:0]];
            end
        end
    end

    // acks merge by OR; a double mapping is forbidden to software
    always_comb begin
        next_ep_ack = '0;
        for (int ch = 0; ch < UFD_NUM_CH; ch++) begin
            next_ep_ack = next_ep_ack | ack_hot[ch];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ep_dma_ack <= '0;
        end else if (ce) begin
            ep_dma_ack <= next_ep_ack;
        end
    end

endmodule

//--- design/ufd_pkg.sv
package ufd_pkg;

    // ==============================
    // register map
    localparam logic [31:0] UFD_MAP_ADDR = 32'hFFFFFDF0;
    localparam logic [31:0] UFD_SCAN_CTRL_ADDR = 32'hFFFFFDF4;
    localparam logic [31:0] UFD_SCAN_STAT_ADDR = 32'hFFFFFDF6;
    localparam logic [31:0] UFD_TOTAL_LEN_ADDR = 32'hFFFFFDF8;
    localparam logic [31:0] UFD_DESC_BASE = 32'hFFFFFEE3;
    localparam logic [15:0] UFD_MAP_RESET = 16'h0000;
    localparam logic [15:0] UFD_MAP_WMASK = 16'h7777;
    localparam int UFD_SCAN_START_BIT = 0;
    localparam int UFD_STAT_BUSY_BIT = 0;
    localparam int UFD_STAT_DONE_BIT = 1;
    localparam int UFD_STAT_ORDER_BIT = 2;
    localparam int UFD_STAT_LEN_BIT = 3;
    localparam int UFD_STAT_IFCNT_LSB = 8;

    // ==============================
    // channel map fields
    localparam int UFD_NUM_CH = 4;
    localparam int UFD_NUM_EP = 4;
    localparam int UFD_SEL_W = 3;
    localparam int UFD_SEL_STRIDE = 4;
    localparam int UFD_SEL_EN_BIT = 2;

    // ==============================
    // descriptor layouts
    localparam logic [7:0] UFD_CFG_LEN = 8'h09;
    localparam logic [7:0] UFD_IF_LEN = 8'h09;
    localparam logic [7:0] UFD_EP_LEN = 8'h07;
    localparam logic [7:0] UFD_CFG_TYPE = 8'h02;
    localparam logic [7:0] UFD_IF_TYPE = 8'h04;
    localparam logic [7:0] UFD_EP_TYPE = 8'h05;
    localparam logic [7:0] UFD_OFS_LEN = 8'h00;
    localparam logic [7:0] UFD_OFS_TYPE = 8'h01;
    localparam logic [7:0] UFD_CFG_TOTAL_LO = 8'h02;
    localparam logic [7:0] UFD_CFG_TOTAL_HI = 8'h03;
    localparam logic [7:0] UFD_CFG_NUM_IF = 8'h04;
    localparam logic [7:0] UFD_CFG_VALUE = 8'h05;
    localparam logic [7:0] UFD_CFG_STRING = 8'h06;
    localparam logic [7:0] UFD_CFG_ATTR = 8'h07;
    localparam logic [7:0] UFD_CFG_POWER = 8'h08;
    localparam logic [7:0] UFD_IF_NUMBER = 8'h02;
    localparam logic [7:0] UFD_IF_ALT = 8'h03;
    localparam logic [7:0] UFD_IF_NUM_EP = 8'h04;
    localparam logic [7:0] UFD_IF_CLASS = 8'h05;
    localparam logic [7:0] UFD_IF_SUBCLASS = 8'h06;
    localparam logic [7:0] UFD_IF_PROTOCOL = 8'h07;
    localparam logic [7:0] UFD_IF_STRING = 8'h08;
    localparam logic [7:0] UFD_EP_ADDR = 8'h02;
    localparam logic [7:0] UFD_EP_ATTR = 8'h03;
    localparam logic [7:0] UFD_EP_MPS_LO = 8'h04;
    localparam logic [7:0] UFD_EP_MPS_HI = 8'h05;
    localparam logic [7:0] UFD_EP_INTERVAL = 8'h06;

    // ==============================
    // carriers
    typedef struct packed {
        logic assigned;
        logic [1:0] endpoint;
    } ufd_route_s;

    typedef struct packed {
        logic valid;
        logic [15:0] total_len;
        logic [7:0] num_if;
        logic [7:0] cfg_value;
        logic [7:0] string_idx;
        logic [7:0] attr;
        logic [7:0] max_power;
    } ufd_cfg_info_s;

    typedef struct packed {
        logic valid;
        logic dir_in;
        logic [1:0] xfer;
        logic [15:0] max_packet;
        logic [7:0] interval;
    } ufd_ep_info_s;

endpackage

//--- tb/ufd_dma_desc_asserts.sv
`timescale 1ns/10ps
module ufd_dma_desc_asserts
    import ufd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // dma path
    input wire logic [UFD_NUM_EP-1:0] ep_dma_req,
    input wire logic [UFD_NUM_EP-1:0] ep_dma_ack,
    input wire logic [UFD_NUM_CH-1:0] ch_dma_req,
    input wire logic [UFD_NUM_CH-1:0] ch_dma_ack,
    input wire ufd_route_s [UFD_NUM_CH-1:0] ch_route
);
    // ==============================
    // expected dma routing
    logic [3:0] exp_req;
    logic [3:0] exp_ack;
    logic [3:0] req_q;
    logic [3:0] ack_q;
    // inputs as the design took them at the last enabled edge, aligned with ch_route
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= 4'h0;
            ack_q <= 4'h0;
        end else if (ce) begin
            req_q <= ep_dma_req;
            ack_q <= ch_dma_ack;
        end
    end
    always_comb begin
        exp_req = 4'h0;
        exp_ack = 4'h0;
        for (int c = 0; c < 4; c++) begin
            exp_req[c] = ch_route[c].assigned & req_q[ch_route[c].endpoint];
            if (ch_route[c].assigned)
                exp_ack[ch_route[c].endpoint] = exp_ack[ch_route[c].endpoint] | ack_q[c];
        end
    end

    // ==============================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence map_wr_s;
        ce && reg_wr && reg_addr == UFD_MAP_ADDR;
    endsequence
    sequence map_rd_s;
        ce && reg_rd && reg_addr == UFD_MAP_ADDR;
    endsequence
    map_zero_a: assert property (map_rd_s |=> (reg_rdata & 16'h8888) == 16'h0000)
        else $error("map reserved bits read nonzero");
    write_read_a: assert property (map_wr_s ##1 map_rd_s |=> reg_rdata == ($past(reg_wdata, 2) & 16'h7777))
        else $error("map readback differs from written word");
    route_ch0_a: assert property (map_wr_s ##1 ce |=> ch_route[0] == $past(reg_wdata[2:0], 2))
        else $error("channel 0 route wrong");
    route_ch3_a: assert property (map_wr_s ##1 ce |=> ch_route[3] == $past(reg_wdata[14:12], 2))
        else $error("channel 3 route wrong");
    chan_req_a: assert property (ce |=> ch_dma_req == exp_req)
        else $error("channel request not from mapped endpoint");
    ep_ack_a: assert property (ce |=> ep_dma_ack == exp_ack)
        else $error("endpoint ack not from mapped channel");
    reset_map_a: assert property ($fell(rst) |-> ch_route == '0)
        else $error("map not cleared by reset");
    unmapped_rd_a: assert property (ce && reg_rd && reg_addr == 32'hFFFFFDF2 |=> reg_rdata == 16'h0000)
        else $error("unmapped read nonzero");
endmodule

//--- tb/ufd_dma_chan_model.sv
`timescale 1ns/10ps
module ufd_dma_chan_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // channel handshake
    input wire logic [3:0] ch_dma_req,
    input wire logic [3:0] slow,
    output logic [3:0] ch_dma_ack
);
    // slow channels answer one cycle later
    logic [3:0] seen;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch_dma_ack <= 4'h0;
            seen <= 4'h0;
        end else begin
            ch_dma_ack <= ch_dma_req & (seen | ~slow);
            seen <= ch_dma_req;
        end
    end
endmodule

//--- tb/tb_ufd_dma_desc.sv
`timescale 1ns/10ps
module tb_ufd_dma_desc;
    import ufd_pkg::*;
    logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, srv_rd = 0;
    logic [31:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, m;
    logic [7:0] srv_idx = 0, srv_data, iface_count;
    logic [3:0] ep_dma_req = 0, ep_dma_ack, ch_dma_req, ch_dma_ack, slow = 0, pr, pa;
    ufd_route_s [3:0] ch_route;
    ufd_cfg_info_s cfg_info;
    ufd_ep_info_s [3:0] ep_info;
    int fail_count = 0, cmp_count = 0, cyc = 0, r;
    logic [7:0] desc [25] = '{8'h09, 8'h02, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, 8'hC0, 8'h32,
        8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00,
        8'h07, 8'h05, 8'h82, 8'h02, 8'h40, 8'h00, 8'h0A};

    ufd_dma_desc ufd_dma_desc_inst (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .srv_rd, .srv_idx, .srv_data, .ep_dma_req, .ep_dma_ack, .ch_dma_req, .ch_dma_ack, .ch_route,
        .cfg_info, .ep_info, .iface_count);
    ufd_dma_chan_model ufd_dma_chan_model_inst (.clk, .rst, .ch_dma_req, .slow, .ch_dma_ack);

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask

    task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d, input logic [15:0] e);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w)
            chk(reg_rdata, e);
    endtask

    task automatic map_wr_rd(input logic [15:0] d);
        @(posedge clk);
        reg_addr <= UFD_MAP_ADDR;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, d & 16'h7777);
    endtask

    function automatic logic [3:0] ereq(logic [15:0] mp, logic [3:0] q);
        ereq = 4'h0;
        for (int c = 0; c < 4; c++)
            if (mp[c*4+2])
                ereq[c] = q[mp[c*4 +: 2]];
    endfunction

    function automatic logic [3:0] eack(logic [15:0] mp, logic [3:0] q);
        eack = 4'h0;
        for (int c = 0; c < 4; c++)
            if (mp[c*4+2])
                eack[mp[c*4 +: 2]] = eack[mp[c*4 +: 2]] | q[c];
    endfunction

    initial begin
        r = $urandom(32'h7C6B);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc(0, UFD_MAP_ADDR, 16'h0000, UFD_MAP_RESET);
        acc(1, 32'hFFFFFDF2, 16'hFFFF, 16'h0000);
        acc(0, 32'hFFFFFDF2, 16'h0000, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            r = $urandom;
            m = 16'(r) & 16'h8888;
            // one distinct endpoint per channel
            for (int c = 0; c < 4; c++)
                m[c*4 +: 3] = {r[c+4], 2'(c) + r[9:8]};
            map_wr_rd(m);
            slow <= 4'($urandom);
            // traffic only after the map is set
            for (int k = 0; k < 16; k++) begin
                @(posedge clk);
                pr = ep_dma_req;
                pa = ch_dma_ack;
                ep_dma_req <= 4'($urandom);
                #1;
                chk(ch_dma_req, ereq(m, pr));
                chk(ep_dma_ack, eack(m, pa));
            end
        end
        // clock enable low freezes the map against a write
        @(posedge clk);
        ce <= 1'b0;
        acc(1, UFD_MAP_ADDR, 16'h4444, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        acc(0, UFD_MAP_ADDR, 16'h0000, m & 16'h7777);
        for (int i = 0; i < 25; i++)
            acc(1, UFD_DESC_BASE + 32'(i), {8'h00, desc[i]}, 16'h0000);
        acc(1, UFD_SCAN_CTRL_ADDR, 16'h0001, 16'h0000);
        repeat (6) @(posedge clk);
        acc(0, UFD_SCAN_STAT_ADDR, 16'h0000, 16'h0102);
        chk(cfg_info, {7'h0, 1'b1, desc[3], desc[2], desc[4], desc[5], desc[6], desc[7], desc[8]});
        chk(ep_info[1], {36'h0, 1'b1, desc[20][7], desc[21][1:0], desc[23], desc[22], desc[24]});
        chk(iface_count, 8'h01);
        for (int i = 0; i < 8; i++) begin
            r = $urandom % 25;
            @(posedge clk);
            srv_rd <= 1'b1;
            srv_idx <= 8'(r);
            @(posedge clk);
            srv_rd <= 1'b0;
            #1;
            chk(srv_data, desc[r]);
        end
        end_of_test();
    end
endmodule

bind ufd_dma_desc ufd_dma_desc_asserts ufd_dma_desc_asserts_inst (.clk, .rst, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ep_dma_req, .ep_dma_ack, .ch_dma_req, .ch_dma_ack, .ch_route);
